// File: rtl/sbcc_pkg.sv
// Constants for the 16-bit counter with input capture.
// Assumes an 8-bit register port and one 50 MHz system clock.
package sbcc_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [3:0] OFS_TIMER_CONTROL_A   = 4'h0;
    localparam logic [3:0] OFS_TIMER_CONTROL_B   = 4'h1;
    localparam logic [3:0] OFS_COUNT_LOWER       = 4'h2;
    localparam logic [3:0] OFS_COUNT_UPPER       = 4'h3;
    localparam logic [3:0] OFS_CAPTURE_LOWER     = 4'h4;
    localparam logic [3:0] OFS_CAPTURE_UPPER     = 4'h5;
    localparam logic [3:0] OFS_COMPARE_A_LOWER   = 4'h6;
    localparam logic [3:0] OFS_COMPARE_A_UPPER   = 4'h7;
    localparam logic [3:0] OFS_IRQ_ENABLE        = 4'h8;
    localparam logic [3:0] OFS_IRQ_FLAGS         = 4'h9;
    localparam logic [3:0] OFS_COMPARATOR_CTRL   = 4'hA;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_TCA_WGM_LO     = 0;  // mode bits 1:0
    localparam int BIT_TCB_CS_LO      = 0;  // clock select 2:0
    localparam int BIT_TCB_WGM_HI     = 3;  // mode bits 3:2
    localparam int BIT_TCB_EDGE       = 6;  // 1 = rising edge
    localparam int BIT_TCB_FILTER     = 7;  // noise filter enable
    localparam int BIT_OVERFLOW       = 0;  // in enable and flags
    localparam int BIT_CAPTURE        = 5;  // in enable and flags
    localparam int BIT_CMP_CAPTURE    = 2;  // comparator select

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_WORD  = 16'h0000;

    // ************************************************************
    // Counting and timing constants
    // ************************************************************
    localparam logic [15:0] TOP_8BIT   = 16'h00FF;
    localparam logic [15:0] TOP_9BIT   = 16'h01FF;
    localparam logic [15:0] TOP_10BIT  = 16'h03FF;
    localparam logic [15:0] MAX_VALUE  = 16'hFFFF;
    localparam logic [15:0] BOTTOM_VAL = 16'h0000;
    localparam int          FILTER_SAMPLES = 4;
    localparam int          PRESCALE_BITS  = 10;

    // Prescaler tap masks
    localparam logic [9:0] PSC_DIV8    = 10'h007;
    localparam logic [9:0] PSC_DIV64   = 10'h03F;
    localparam logic [9:0] PSC_DIV256  = 10'h0FF;
    localparam logic [9:0] PSC_DIV1024 = 10'h3FF;

    // Clock select codes
    localparam logic [2:0] CS_STOP     = 3'h0;
    localparam logic [2:0] CS_DIV1     = 3'h1;
    localparam logic [2:0] CS_DIV8     = 3'h2;
    localparam logic [2:0] CS_DIV64    = 3'h3;
    localparam logic [2:0] CS_DIV256   = 3'h4;
    localparam logic [2:0] CS_DIV1024  = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    // Counting sequence families
    typedef enum {
        SBCC_SEQ_NORMAL,
        SBCC_SEQ_CTC,
        SBCC_SEQ_FAST,
        SBCC_SEQ_PHASE
    } sbcc_seq_t;

    // Top source choices
    typedef enum {
        SBCC_TOP_MAX,
        SBCC_TOP_8,
        SBCC_TOP_9,
        SBCC_TOP_10,
        SBCC_TOP_CMPA,
        SBCC_TOP_CAPT
    } sbcc_top_t;

endpackage

// File: rtl/sbcc_timer.sv
// 16-bit up/down counter with shared high-byte latch and input capture.
// Assumes a one-cycle strobe register port and async capture inputs.
//
// Contract
// - Clock select picks source; zero stops counting
// - Bidirectional 16-bit counter with count and clear
// - Top and bottom indications from the counter
// - Count visible at upper and lower byte locations
// - Count upper location accesses the shared latch
// - Low byte access moves upper byte via latch
// - Software write beats clear and count
// - Each tick clears, increments or decrements by mode
// - Four-bit mode split over two control registers
// - Overflow flag set per mode, requests interrupt
// - Matching edge on capture source triggers capture
// - Capture copies full count into capture register
// - Capture flag set in the copy cycle
// - Enabled capture flag requests capture interrupt
// - Flag cleared by service or writing one
// - Capture read low first, upper via latch
// - Capture register writable only when it is top
// - Comparator select bit switches capture source
// - Source switch may capture; software clears flag
// - Top is fixed, compare A or capture register
// - Filter needs four equal samples to change
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps

module sbcc_timer
    import sbcc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       capture_pin,
    input  wire logic       comparator_output,
    input  wire logic       ext_clock_pin,
    input  wire logic       overflow_irq_ack,
    input  wire logic       capture_irq_ack,
    output logic            overflow_irq,
    output logic            capture_irq,
    output logic            count_at_top,
    output logic            count_at_bottom
);

    // ************************************************************
    // Decoding helpers
    // ************************************************************

    // Sequence family for a mode code
    function automatic sbcc_seq_t seq_of(input logic [3:0] m);
        unique case (m)
            4'h1, 4'h2, 4'h3,
            4'h8, 4'h9, 4'hA, 4'hB: seq_of = SBCC_SEQ_PHASE;
            4'h4, 4'hC:             seq_of = SBCC_SEQ_CTC;
            4'h5, 4'h6, 4'h7,
            4'hE, 4'hF:             seq_of = SBCC_SEQ_FAST;
            default:                seq_of = SBCC_SEQ_NORMAL;
        endcase
    endfunction

    // Top source for a mode code
    function automatic sbcc_top_t top_of(input logic [3:0] m);
        unique case (m)
            4'h1, 4'h5:             top_of = SBCC_TOP_8;
            4'h2, 4'h6:             top_of = SBCC_TOP_9;
            4'h3, 4'h7:             top_of = SBCC_TOP_10;
            4'h4, 4'h9, 4'hB, 4'hF: top_of = SBCC_TOP_CMPA;
            4'h8, 4'hA, 4'hC, 4'hE: top_of = SBCC_TOP_CAPT;
            default:                top_of = SBCC_TOP_MAX;
        endcase
    endfunction

    // ************************************************************
    // Register state
    // ************************************************************
    logic [7:0]  tca_ff, nxt_tca;
    logic [7:0]  tcb_ff, nxt_tcb;
    logic [7:0]  ien_ff, nxt_ien;
    logic [7:0]  acr_ff, nxt_acr;
    logic [7:0]  latch_ff, nxt_latch;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [15:0] capt_ff, nxt_capt;
    logic [15:0] cmpa_ff, nxt_cmpa;
    logic        dir_down_ff, nxt_dir_down;
    logic        ovf_ff, nxt_ovf;
    logic        capf_ff, nxt_capf;
    logic [7:0]  rdata_ff, nxt_rdata;

    // Synchroniser, filter and edge state
    logic [1:0]  pin_sync_ff, cmp_sync_ff, ext_sync_ff;
    logic [FILTER_SAMPLES-1:0] hist_ff, nxt_hist;
    logic        filt_ff, nxt_filt;
    logic        cap_prev_ff, nxt_cap_prev;
    logic        ext_prev_ff, nxt_ext_prev;
    logic [PRESCALE_BITS-1:0] psc_ff, nxt_psc;

    // Decoded control
    logic [3:0]  wgm;
    logic [2:0]  clk_sel;
    sbcc_seq_t   seq;
    sbcc_top_t   top_sel;
    logic [15:0] top_val;
    logic        tick;
    logic        cap_src;
    logic        cap_level;
    logic        cap_event;
    logic        capt_is_top;
    logic        wr_cnt_lo;
    logic        ovf_set;

    // Mode field split over both control registers
    assign wgm     = {tcb_ff[BIT_TCB_WGM_HI+1:BIT_TCB_WGM_HI],
                      tca_ff[BIT_TCA_WGM_LO+1:BIT_TCA_WGM_LO]};
    assign clk_sel = tcb_ff[BIT_TCB_CS_LO+2:BIT_TCB_CS_LO];
    assign seq     = seq_of(wgm);
    assign top_sel = top_of(wgm);
    assign capt_is_top = (top_sel == SBCC_TOP_CAPT);

    // Top value per mode
    always_comb begin
        unique case (top_sel)
            SBCC_TOP_8:    top_val = TOP_8BIT;
            SBCC_TOP_9:    top_val = TOP_9BIT;
            SBCC_TOP_10:   top_val = TOP_10BIT;
            SBCC_TOP_CMPA: top_val = cmpa_ff;
            SBCC_TOP_CAPT: top_val = capt_ff;
            SBCC_TOP_MAX:  top_val = MAX_VALUE;
        endcase
    end

    // Top and bottom indications
    assign count_at_top    = (cnt_ff == top_val);
    assign count_at_bottom = (cnt_ff == BOTTOM_VAL);

    // ************************************************************
    // Input synchronisers
    // ************************************************************

    // Two flops per async input; only stage 2 is read
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_sync_ff <= 2'h0;
            cmp_sync_ff <= 2'h0;
            ext_sync_ff <= 2'h0;
        end else begin
            pin_sync_ff <= {pin_sync_ff[0], capture_pin};
            cmp_sync_ff <= {cmp_sync_ff[0], comparator_output};
            ext_sync_ff <= {ext_sync_ff[0], ext_clock_pin};
        end
    end

    // ************************************************************
    // Capture filter and edge detector
    // ************************************************************

    // Comparator replaces the pin when selected
    assign cap_src = acr_ff[BIT_CMP_CAPTURE] ? cmp_sync_ff[1]
                                             : pin_sync_ff[1];
    assign cap_level = tcb_ff[BIT_TCB_FILTER] ? filt_ff : cap_src;

    // Edge must match the chosen sense; blocked while capture is top
    assign cap_event = (cap_level != cap_prev_ff)
                     && (cap_level == tcb_ff[BIT_TCB_EDGE])
                     && !capt_is_top;

    // Filter output moves only on a full run of equal samples
    always_comb begin
        nxt_hist     = {hist_ff[FILTER_SAMPLES-2:0], cap_src};
        nxt_filt     = filt_ff;
        nxt_cap_prev = cap_level;
        if (&hist_ff) nxt_filt = 1'b1;
        else if (~|hist_ff) nxt_filt = 1'b0;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            hist_ff     <= '0;
            filt_ff     <= 1'b0;
            cap_prev_ff <= 1'b0;
        end else begin
            hist_ff     <= nxt_hist;
            filt_ff     <= nxt_filt;
            cap_prev_ff <= nxt_cap_prev;
        end
    end

    // ************************************************************
    // Clock select and prescaler
    // ************************************************************

    // Free-running prescaler keeps taps aligned across selections
    always_comb begin
        nxt_psc      = psc_ff + 1'b1;
        nxt_ext_prev = ext_sync_ff[1];
        unique case (clk_sel)
            CS_STOP:     tick = 1'b0;
            CS_DIV1:     tick = 1'b1;
            CS_DIV8:     tick = (psc_ff & PSC_DIV8) == PSC_DIV8;
            CS_DIV64:    tick = (psc_ff & PSC_DIV64) == PSC_DIV64;
            CS_DIV256:   tick = (psc_ff & PSC_DIV256) == PSC_DIV256;
            CS_DIV1024:  tick = psc_ff == PSC_DIV1024;
            CS_EXT_FALL: tick = ext_prev_ff && !ext_sync_ff[1];
            CS_EXT_RISE: tick = !ext_prev_ff && ext_sync_ff[1];
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            psc_ff      <= '0;
            ext_prev_ff <= 1'b0;
        end else begin
            psc_ff      <= nxt_psc;
            ext_prev_ff <= nxt_ext_prev;
        end
    end

    // ************************************************************
    // Counter unit
    // ************************************************************
    assign wr_cnt_lo = reg_wr && (reg_addr == OFS_COUNT_LOWER);

    // Write first, then the mode's count step on each tick
    always_comb begin
        nxt_cnt      = cnt_ff;
        nxt_dir_down = dir_down_ff;
        ovf_set      = 1'b0;
        if (wr_cnt_lo) begin
            nxt_cnt = {latch_ff, reg_wdata};
        end else if (tick) begin
            unique case (seq)
                SBCC_SEQ_NORMAL: begin
                    nxt_cnt = cnt_ff + 16'h0001;
                    ovf_set = (cnt_ff == MAX_VALUE);
                end
                // CTC overflows only if it ran past top to max; fast overflows at top
                SBCC_SEQ_CTC, SBCC_SEQ_FAST: begin
                    nxt_cnt = count_at_top ? BOTTOM_VAL
                                           : cnt_ff + 16'h0001;
                    ovf_set = (seq == SBCC_SEQ_FAST) ? count_at_top
                                                     : (cnt_ff == MAX_VALUE);
                end
                SBCC_SEQ_PHASE: begin
                    // Turn at both ends; overflow at the bottom turn
                    nxt_dir_down = dir_down_ff ? !count_at_bottom
                                               : (cnt_ff >= top_val);
                    ovf_set      = dir_down_ff && count_at_bottom;
                    nxt_cnt      = nxt_dir_down ? cnt_ff - 16'h0001
                                                : cnt_ff + 16'h0001;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_ff      <= RST_WORD;
            dir_down_ff <= 1'b0;
        end else begin
            cnt_ff      <= nxt_cnt;
            dir_down_ff <= nxt_dir_down;
        end
    end

    // ************************************************************
    // Registers, latch, capture and flags
    // ************************************************************

    // Byte accesses, capture copy and flags
    always_comb begin
        nxt_tca   = tca_ff;
        nxt_tcb   = tcb_ff;
        nxt_ien   = ien_ff;
        nxt_acr   = acr_ff;
        nxt_latch = latch_ff;
        nxt_capt  = capt_ff;
        nxt_cmpa  = cmpa_ff;
        nxt_ovf   = ovf_ff;
        nxt_capf  = capf_ff;
        nxt_rdata = RST_BYTE;
        if (reg_wr) begin
            unique case (reg_addr)
                OFS_TIMER_CONTROL_A: nxt_tca = reg_wdata;
                OFS_TIMER_CONTROL_B: nxt_tcb = reg_wdata;
                OFS_IRQ_ENABLE:      nxt_ien = reg_wdata;
                OFS_COMPARATOR_CTRL: nxt_acr = reg_wdata;
                // Upper locations only ever load the latch
                OFS_COUNT_UPPER,
                OFS_CAPTURE_UPPER,
                OFS_COMPARE_A_UPPER: nxt_latch = reg_wdata;
                OFS_CAPTURE_LOWER:
                    if (capt_is_top) nxt_capt = {latch_ff, reg_wdata};
                OFS_COMPARE_A_LOWER: nxt_cmpa = {latch_ff, reg_wdata};
                OFS_IRQ_FLAGS: begin
                    // Write one to clear
                    if (reg_wdata[BIT_OVERFLOW]) nxt_ovf = 1'b0;
                    if (reg_wdata[BIT_CAPTURE]) nxt_capf = 1'b0;
                end
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_TIMER_CONTROL_A: nxt_rdata = tca_ff;
                OFS_TIMER_CONTROL_B: nxt_rdata = tcb_ff;
                OFS_IRQ_ENABLE:      nxt_rdata = ien_ff;
                OFS_COMPARATOR_CTRL: nxt_rdata = acr_ff;
                OFS_COUNT_LOWER: begin
                    nxt_rdata = cnt_ff[7:0];
                    nxt_latch = cnt_ff[15:8];
                end
                OFS_CAPTURE_LOWER: begin
                    nxt_rdata = capt_ff[7:0];
                    nxt_latch = capt_ff[15:8];
                end
                // Upper locations return the latch
                OFS_COUNT_UPPER,
                OFS_CAPTURE_UPPER:   nxt_rdata = latch_ff;
                // Compare A is read direct, no latch involved
                OFS_COMPARE_A_LOWER: nxt_rdata = cmpa_ff[7:0];
                OFS_COMPARE_A_UPPER: nxt_rdata = cmpa_ff[15:8];
                OFS_IRQ_FLAGS: begin
                    nxt_rdata[BIT_OVERFLOW] = ovf_ff;
                    nxt_rdata[BIT_CAPTURE]  = capf_ff;
                end
                default: ;
            endcase
        end
        // Service acknowledges clear their flags
        if (overflow_irq_ack) nxt_ovf = 1'b0;
        if (capture_irq_ack) nxt_capf = 1'b0;
        // Hardware set wins over any clear in the same cycle
        if (ovf_set) nxt_ovf = 1'b1;
        if (cap_event) begin
            nxt_capt = cnt_ff;
            nxt_capf = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tca_ff   <= RST_BYTE;
            tcb_ff   <= RST_BYTE;
            ien_ff   <= RST_BYTE;
            acr_ff   <= RST_BYTE;
            latch_ff <= RST_BYTE;
            capt_ff  <= RST_WORD;
            cmpa_ff  <= RST_WORD;
            ovf_ff   <= 1'b0;
            capf_ff  <= 1'b0;
            rdata_ff <= RST_BYTE;
        end else begin
            tca_ff   <= nxt_tca;
            tcb_ff   <= nxt_tcb;
            ien_ff   <= nxt_ien;
            acr_ff   <= nxt_acr;
            latch_ff <= nxt_latch;
            capt_ff  <= nxt_capt;
            cmpa_ff  <= nxt_cmpa;
            ovf_ff   <= nxt_ovf;
            capf_ff  <= nxt_capf;
            rdata_ff <= nxt_rdata;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign reg_rdata    = rdata_ff;
    assign overflow_irq = ovf_ff && ien_ff[BIT_OVERFLOW];
    assign capture_irq  = capf_ff && ien_ff[BIT_CAPTURE];

endmodule

// File: verif/sbcc_timer_properties.sv
// Port checker for the counter with input capture.
// Assumes the one-cycle strobe register port and one clock.
`timescale 1ns/1ps

module sbcc_timer_properties
    import sbcc_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       capture_pin,
    input wire logic       comparator_output,
    input wire logic       ext_clock_pin,
    input wire logic       overflow_irq_ack,
    input wire logic       capture_irq_ack,
    input wire logic       overflow_irq,
    input wire logic       capture_irq,
    input wire logic       count_at_top,
    input wire logic       count_at_bottom
);
    // ****
    // Helpers
    // ****
    logic [1:0] en_ff, nxt_en;
    logic [3:0] quiet_ff, nxt_quiet;
    logic       pin_ff, cmp_ff;
    // Captures land within 8 cycles; 12 quiet cycles leaves margin
    always_comb begin
        nxt_en = en_ff;
        if (reg_wr && reg_addr == OFS_IRQ_ENABLE) begin
            nxt_en = {reg_wdata[BIT_CAPTURE], reg_wdata[BIT_OVERFLOW]};
        end
        nxt_quiet = (quiet_ff == 4'hF) ? 4'hF : quiet_ff + 4'h1;
        if (capture_pin != pin_ff || comparator_output != cmp_ff ||
            (reg_wr && reg_addr inside {OFS_TIMER_CONTROL_A,
             OFS_TIMER_CONTROL_B, OFS_COMPARATOR_CTRL})) begin
            nxt_quiet = 4'h0;
        end
    end
    always_ff @(posedge sys_clk) begin
        en_ff    <= rst_n ? nxt_en : 2'h0;
        quiet_ff <= rst_n ? nxt_quiet : 4'h0;
        pin_ff   <= capture_pin;
        cmp_ff   <= comparator_output;
    end
    wire quiet = quiet_ff >= 4'hC;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_count_zero;
        reg_wr && reg_addr == OFS_COUNT_UPPER && reg_wdata == 8'h00
        ##1 !reg_wr && !reg_rd
        ##1 reg_wr && reg_addr == OFS_COUNT_LOWER && reg_wdata == 8'h00;
    endsequence
    sequence s_latch_peek;
        reg_wr && reg_addr == OFS_COUNT_UPPER ##1 !reg_wr && !reg_rd
        ##1 reg_rd && reg_addr == OFS_CAPTURE_UPPER;
    endsequence
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero without read");
    a_unmapped_zero: assert property (reg_rd &&
        reg_addr > OFS_COMPARATOR_CTRL |=> reg_rdata == 8'h00)
        else $error("unmapped offset read nonzero");
    a_write_wins: assert property (s_count_zero |=> count_at_bottom)
        else $error("count write did not land");
    a_latch_reuse: assert property (s_latch_peek
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("upper location did not return latch");
    a_reset_bottom: assert property ($rose(rst_n)
        |-> count_at_bottom)
        else $error("count not at bottom after reset");
    a_ovf_gated: assert property (!en_ff[0] |-> !overflow_irq)
        else $error("overflow request while disabled");
    a_capt_gated: assert property (!en_ff[1] |-> !capture_irq)
        else $error("capture request while disabled");
    a_capt_cause: assert property ($rose(capture_irq)
        |-> !quiet || $past(reg_wr))
        else $error("capture request without input change");
    a_capt_wclear: assert property (reg_wr &&
        reg_addr == OFS_IRQ_FLAGS && reg_wdata[BIT_CAPTURE] && quiet
        |=> !capture_irq)
        else $error("write one did not clear capture flag");
    a_capt_ack: assert property (capture_irq_ack && quiet
        |=> !capture_irq)
        else $error("service did not clear capture flag");
endmodule

bind sbcc_timer sbcc_timer_properties sbcc_timer_properties_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .capture_pin(capture_pin),
    .comparator_output(comparator_output), .ext_clock_pin(ext_clock_pin),
    .overflow_irq_ack(overflow_irq_ack), .capture_irq_ack(capture_irq_ack),
    .overflow_irq(overflow_irq), .capture_irq(capture_irq),
    .count_at_top(count_at_top), .count_at_bottom(count_at_bottom));

// File: verif/sbcc_cpu_model.sv
// Processor-side bus model: byte and 16-bit register accesses.
// Assumes each call starts just after a rising edge of sys_clk.
`timescale 1ns/1ps

module sbcc_cpu_model
    import sbcc_pkg::*;
(
    input  wire logic       sys_clk,
    output logic      [3:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    // ****
    // Bus cycles, one idle cycle after each strobe
    // ****
    initial begin
        reg_addr  = 4'h0;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge sys_clk);
    endtask
    // No handler here, so pairs are never split
    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        wr(a + 4'h1, v[15:8]);
        wr(a, v[7:0]);
    endtask
    task automatic rd16(input logic [3:0] a, output logic [15:0] v);
        logic [7:0] lo, hi;
        rd(a, lo);
        rd(a + 4'h1, hi);
        v = {hi, lo};
    endtask
endmodule

// File: verif/tb.sv
// Self-checking bench for the counter with input capture.
// Assumes the bus model and the bound port checker.
`timescale 1ns/1ps

module tb;
    import sbcc_pkg::*;
    logic        sys_clk, rst_n, cap_pin, cmp_out, cap_ack;
    logic [3:0]  addr;
    logic [7:0]  wdata, rdata, b;
    logic        wr, rd, ovf_irq, cap_irq, at_top, at_bot;
    logic [15:0] w;
    logic [15:0] tops [3] = '{TOP_8BIT, TOP_9BIT, TOP_10BIT};
    int          fail_count = 0;
    int          n_tests = 0;
    sbcc_timer sbcc_timer_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdata), .capture_pin(cap_pin),
        .comparator_output(cmp_out), .ext_clock_pin(1'b0),
        .overflow_irq_ack(1'b0), .capture_irq_ack(cap_ack),
        .overflow_irq(ovf_irq), .capture_irq(cap_irq),
        .count_at_top(at_top), .count_at_bottom(at_bot));
    sbcc_cpu_model cpu (.sys_clk(sys_clk), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
    // ****
    // Checks and verdict
    // ****
    task automatic chk(input logic [15:0] s, e, input string nm);
        n_tests++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic flags(input logic [7:0] e, input string nm);
        cpu.rd(OFS_IRQ_FLAGS, b);
        chk(b, e, nm);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always #10 sys_clk = ~sys_clk;
    // Whole run is a few hundred cycles; this limit is generous
    initial begin
        #400000;
        fail_count++;
        end_of_test();
    end
    initial begin
        {sys_clk, rst_n, cap_pin, cmp_out, cap_ack} = 5'h00;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        for (int a = 0; a < 12; a++) begin
            cpu.rd(4'(a), b);
            chk(b, 8'h00, "reset");
        end
        for (int m = 1; m < 4; m++) begin
            cpu.wr(OFS_TIMER_CONTROL_A, 8'(m));
            cpu.wr16(OFS_COUNT_LOWER, tops[m-1]);
            #1 chk(at_top, 1'b1, "top");
            @(posedge sys_clk);
            cpu.wr16(OFS_COUNT_LOWER, tops[m-1] - 16'h0001);
            #1 chk(at_top, 1'b0, "below top");
            @(posedge sys_clk);
        end
        cpu.wr(OFS_TIMER_CONTROL_A, 8'h00);
        cpu.wr16(OFS_COUNT_LOWER, 16'h01FF);
        repeat (5) @(posedge sys_clk);
        cpu.rd16(OFS_COUNT_LOWER, w);
        chk(w, 16'h01FF, "stopped count");
        cpu.wr(OFS_COUNT_UPPER, 8'h5A);
        cpu.rd(OFS_CAPTURE_UPPER, b);
        chk(b, 8'h5A, "shared latch");
        // Overflow from 0xFFFF at full rate, then stop
        cpu.wr(OFS_IRQ_ENABLE, 8'h21);
        cpu.wr16(OFS_COUNT_LOWER, 16'hFFFE);
        cpu.wr(OFS_TIMER_CONTROL_B, 8'h41);
        for (int i = 0; i < 20 && ovf_irq !== 1'b1; i++) @(posedge sys_clk);
        chk(ovf_irq, 1'b1, "ovf irq");
        cpu.wr16(OFS_COUNT_LOWER, 16'h0000);
        cpu.wr(OFS_TIMER_CONTROL_B, 8'h40);
        flags(8'h01, "ovf flag");
        cpu.wr(OFS_IRQ_FLAGS, 8'h01);
        flags(8'h00, "ovf clear");
        // Rising capture, then service acknowledge
        cpu.wr16(OFS_COUNT_LOWER, 16'h0ABC);
        cap_pin <= 1'b1;
        repeat (8) @(posedge sys_clk);
        cpu.rd16(OFS_CAPTURE_LOWER, w);
        chk(w, 16'h0ABC, "capture");
        flags(8'h20, "capt flag");
        #1 chk(cap_irq, 1'b1, "capt irq");
        @(posedge sys_clk);
        cap_ack <= 1'b1;
        @(posedge sys_clk);
        cap_ack <= 1'b0;
        #1 chk(cap_irq, 1'b0, "capt ack");
        @(posedge sys_clk);
        // Wrong edge, short glitch under filter, then a real edge
        cpu.wr16(OFS_COUNT_LOWER, 16'h0555);
        cap_pin <= 1'b0;
        repeat (12) @(posedge sys_clk);
        flags(8'h00, "falling ignored");
        cpu.wr(OFS_TIMER_CONTROL_B, 8'hC0);
        cap_pin <= 1'b1;
        repeat (2) @(posedge sys_clk);
        cap_pin <= 1'b0;
        repeat (12) @(posedge sys_clk);
        flags(8'h00, "glitch filtered");
        cap_pin <= 1'b1;
        repeat (12) @(posedge sys_clk);
        flags(8'h20, "filtered edge");
        cpu.wr(OFS_IRQ_FLAGS, 8'h20);
        flags(8'h00, "write one");
        // Comparator as source; flag cleared after the switch
        cpu.wr16(OFS_COUNT_LOWER, 16'h0777);
        cpu.wr(OFS_COMPARATOR_CTRL, 8'h04);
        cpu.wr(OFS_IRQ_FLAGS, 8'h20);
        cmp_out <= 1'b1;
        repeat (12) @(posedge sys_clk);
        cpu.rd16(OFS_CAPTURE_LOWER, w);
        chk(w, 16'h0777, "comparator capture");
        // Capture register writable only while top, here in mode 8
        cpu.wr16(OFS_CAPTURE_LOWER, 16'h0123);
        cpu.rd16(OFS_CAPTURE_LOWER, w);
        chk(w, 16'h0777, "capture write ignored");
        cpu.wr(OFS_TIMER_CONTROL_B, 8'h10);
        cpu.wr16(OFS_CAPTURE_LOWER, 16'h0123);
        cpu.wr16(OFS_COUNT_LOWER, 16'h0123);
        #1 chk(at_top, 1'b1, "capture top");
        @(posedge sys_clk);
        cpu.wr(4'hB, 8'hFF);
        cpu.rd(4'hB, b);
        chk(b, 8'h00, "unmapped");
        end_of_test();
    end
endmodule
